/* erbe_consts.svh */
`ifndef ERBE_CONSTS_SVH
`define ERBE_CONSTS_SVH

// array geometry
`define ERBE_AW        9
`define ERBE_DEPTH     512
`define ERBE_DW        40
`define ERBE_MW        44
`define ERBE_LANES     4
`define ERBE_LW        10
`define ERBE_EDW       32
`define ERBE_HCW       6

// apb register byte offsets
`define ERBE_PAW       12
`define ERBE_REG_CFG   12'h000
`define ERBE_REG_STAT  12'h004
`define ERBE_REG_CNT   12'h008

// configuration register fields
`define ERBE_CFG_MODE_HI 2
`define ERBE_CFG_MODE_LO 0
`define ERBE_CFG_DC_BIT  3
`define ERBE_CFG_PIPE_BIT 4
`define ERBE_CFG_PACK_BIT 5

// read-data positions of the ecc status pair
`define ERBE_ST_ERR    39
`define ERBE_ST_UE     38

// value shown on a masked lane when the don't-care option is chosen
`define ERBE_DC_LANE   10'h000

`endif

/* erbe_fab_model.sv */
`timescale 1ns/1ps
`include "erbe_consts.svh"

// fabric user of one ram port; released address and data lines show the inverse of the last
// value so that a port sampling them out of turn is caught
module erbe_fab_model (
   input  wire logic                   clk,
   input  wire logic                   ecc_on,
   output logic [`ERBE_AW-1:0]    addr,
   output logic                        wren,
   output logic                        rden,
   output logic [`ERBE_LANES-1:0] byteen,
   output logic [`ERBE_DW-1:0]    wdata,
   output logic                        clken,
   output logic                        stall
);
   initial begin
      addr   = '0;
      wren   = 1'b0;
      rden   = 1'b0;
      byteen = 4'hF;
      wdata  = '0;
      clken  = 1'b0;
      stall  = 1'b0;
   end

   task automatic req(input logic w, input logic r, input logic [3:0] be,
                      input logic [8:0] a, input logic [39:0] d, input logic s);
      @(posedge clk);
      addr   <= a;
      wren   <= w;
      rden   <= r & ~(ecc_on & w);
      byteen <= ecc_on ? 4'hF : be;
      wdata  <= d;
      clken  <= 1'b1;
      stall  <= s;
      @(posedge clk);
      addr   <= ~a;
      wren   <= 1'b0;
      rden   <= 1'b0;
      wdata  <= ~d;
      clken  <= 1'b0;
      stall  <= 1'b0;
   endtask
endmodule

/* erbe_mem.sv */
`timescale 1ns/1ps
`include "erbe_consts.svh"

// two-port array; read data is registered and shows the contents before
// a write landing on the same edge. same-address writes: port b wins.
module erbe_mem (
   input  wire logic   pclk,
   erbe_mem_if.mem     pa,
   erbe_mem_if.mem     pb
);
   logic [`ERBE_MW-1:0] arr [`ERBE_DEPTH];

   always_ff @(posedge pclk) begin
      for (int i = 0; i < `ERBE_MW; i++) begin
         if (pa.we && pa.wmask[i]) begin
            arr[pa.addr][i] <= pa.wdata[i];
         end
         if (pb.we && pb.wmask[i]) begin
            arr[pb.addr][i] <= pb.wdata[i];
         end
      end
      pa.rdata <= arr[pa.addr];
      pb.rdata <= arr[pb.addr];
   end
endmodule

/* erbe_mem_if.sv */
`timescale 1ns/1ps
`include "erbe_consts.svh"

interface erbe_mem_if;
   logic [`ERBE_AW-1:0] addr;
   logic                we;
   logic [`ERBE_MW-1:0] wmask;
   logic [`ERBE_MW-1:0] wdata;
   logic [`ERBE_MW-1:0] rdata;

   modport ctl (output addr, output we, output wmask, output wdata, input rdata);
   modport mem (input addr, input we, input wmask, input wdata, output rdata);
endinterface

/* erbe_monitor.sv */
`timescale 1ns/1ps
`include "erbe_consts.svh"

module erbe_monitor (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic [`ERBE_PAW-1:0] paddr,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic [`ERBE_DW-1:0]  a_rdata,
   input wire logic [`ERBE_DW-1:0]  b_rdata,
   input wire logic                 out_clr
);
   logic [2:0] mode_q;
   logic [2:0] quiet_q;
   logic       unmap;
   logic       ecc;
   logic       nar;
   assign unmap = !(paddr inside {`ERBE_REG_CFG, `ERBE_REG_STAT, `ERBE_REG_CNT});
   // a mode is trusted only once words issued under the old one have drained
   assign ecc = quiet_q == 3'h7 && mode_q == 3'h4;
   assign nar = quiet_q == 3'h7 && mode_q == 3'h1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q  <= 3'h2;
         quiet_q <= 3'h7;
      end else if (psel && penable && pwrite && paddr == `ERBE_REG_CFG) begin
         mode_q  <= (pwdata[2:0] inside {3'h1, 3'h2, 3'h4}) ? pwdata[2:0] : mode_q;
         quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   reset_out_a: assert property (disable iff (1'b0) !presetn |-> a_rdata == '0 && b_rdata == '0)
      else $error("read outputs not zero in reset");
   clr_zero_a: assert property (out_clr |-> a_rdata == '0 && b_rdata == '0)
      else $error("outputs not zero during clear");
   clr_stretch_a: assert property (out_clr |=> a_rdata == '0 && b_rdata == '0)
      else $error("clear not held to next edge");
   status_legal_a: assert property (ecc && $changed(b_rdata) |-> b_rdata[39:38] != 2'b01)
      else $error("illegal ecc status");
   flag_slot_a: assert property (ecc && $changed(b_rdata) |-> b_rdata[37:32] == 6'h00)
      else $error("ecc spare bits not zero");
   narrow_zero_a: assert property (nar && $changed(a_rdata) |-> a_rdata[39:20] == 20'h00000)
      else $error("upper half set in narrow mode");
   slverr_map_a: assert property (psel && penable |-> pslverr == unmap)
      else $error("slave error decode wrong");
   unmap_read_a: assert property (psel && unmap |-> prdata == 32'h00000000)
      else $error("unmapped read not zero");

   clr_seen_c: cover property (out_clr);
   ecc_read_c: cover property (ecc && $changed(b_rdata));
   bad_addr_c: cover property (psel && penable && pslverr);
endmodule

/* erbe_pkg.sv */
`include "erbe_consts.svh"

package erbe_pkg;

   typedef enum logic [2:0] {
      ERBE_W20    = 3'b001,
      ERBE_W40    = 3'b010,
      ERBE_W32ECC = 3'b100
   } erbe_mode_t;

   typedef struct packed {
      logic [`ERBE_AW-1:0]    addr;
      logic                   wr;
      logic                   rd;
      logic [`ERBE_LANES-1:0] be;
      logic [`ERBE_DW-1:0]    wd;
      logic                   s2wr;
      logic                   s2rd;
      logic [`ERBE_LANES-1:0] s2be;
      logic [`ERBE_DW-1:0]    s2wd;
      logic                   pv;
      logic [`ERBE_MW-1:0]    praw;
      logic [`ERBE_DW-1:0]    rq;
   } erbe_port_t;

   typedef struct packed {
      erbe_port_t [1:0] pt;
      erbe_mode_t       mode;
      logic             dc;
      logic             pipe;
      logic             packd;
      logic [1:0]       stat;
      logic [15:0]      cnt;
   } erbe_state_t;

   typedef struct packed {
      logic [15:0] d;
      logic        e;
      logic        ue;
   } erbe_half_t;

   typedef struct packed {
      logic [`ERBE_EDW-1:0] d;
      logic                 e;
      logic                 ue;
   } erbe_dec_t;

endpackage

/* erbe_top.sv */
`timescale 1ns/1ps
`include "erbe_consts.svh"

// Operation
// - mask bits gate each 10-bit lane
// - masked lanes show don't-care or stored data
// - packed: port number replaces address msb to pick the half
// - address hold keeps registered address
// - each port has own address hold
// - undriven address hold means inactive low
// - async clear zeroes the read outputs
// - clear stretched to next output clock edge
// - outputs stay zero until next read or write
// - correct single/double-adjacent, detect triple-adjacent errors
// - ecc only in 32-bit simple dual-port
// - optional ecc pipeline adds one cycle
// - ecc flags replace two parity bits
// - status 00 ok, 10 corrected, 11 bad
// - mask active high, lsb to lsb lane
// - each lane is eight data plus two parity
module erbe_top (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [`ERBE_PAW-1:0]   paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [`ERBE_AW-1:0]    a_addr,
   input  wire logic                   a_wren,
   input  wire logic                   a_rden,
   input  wire logic [`ERBE_LANES-1:0] a_byteen,
   input  wire logic [`ERBE_DW-1:0]    a_wdata,
   input  wire logic                   a_clken,
   input  wire logic                   a_addr_stall,
   output logic      [`ERBE_DW-1:0]    a_rdata,
   input  wire logic [`ERBE_AW-1:0]    b_addr,
   input  wire logic                   b_wren,
   input  wire logic                   b_rden,
   input  wire logic [`ERBE_LANES-1:0] b_byteen,
   input  wire logic [`ERBE_DW-1:0]    b_wdata,
   input  wire logic                   b_clken,
   input  wire logic                   b_addr_stall,
   output logic      [`ERBE_DW-1:0]    b_rdata,
   input  wire logic                   out_clr
);
   // data bit positions of a 16-bit hamming word (powers of two hold check bits)
   localparam logic [4:0] HPOS [16] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A,
                                        5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11,
                                        5'h12, 5'h13, 5'h14, 5'h15};
   // reset leaves plain 40-bit mode, every option off
   localparam erbe_pkg::erbe_state_t ST_RST = '{mode: erbe_pkg::ERBE_W40, default: '0};

   erbe_pkg::erbe_state_t  st_q;
   erbe_pkg::erbe_state_t  st_d;
   logic                   clr_seen_q;
   logic                   clr_act;
   logic                   ecc_on;
   logic                   apb_wr;
   logic                   hit_cfg;
   logic                   hit_stat;
   logic                   hit_cnt;
   logic [1:0]             p_wr;
   logic [1:0]             p_rd;
   logic [1:0]             p_ce;
   logic [1:0]             p_stall;
   logic [`ERBE_AW-1:0]    p_addr  [2];
   logic [`ERBE_LANES-1:0] p_be    [2];
   logic [`ERBE_DW-1:0]    p_wd    [2];
   logic [`ERBE_MW-1:0]    m_rd    [2];
   logic                   dv;
   logic [`ERBE_MW-1:0]    raw;
   erbe_pkg::erbe_dec_t    dec;
   logic [`ERBE_DW-1:0]    merged;

   function automatic logic [5:0] enc16(input logic [15:0] d);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < 16; i++) begin
         if (d[i]) begin
            c[4:0] = c[4:0] ^ HPOS[i];
         end
      end
      c[5] = ^{d, c[4:0]};
      return c;
   endfunction

   // secded per half: odd parity mismatch means one error, else a nonzero
   // syndrome means two
   function automatic erbe_pkg::erbe_half_t dec16(input logic [15:0] d,
                                                  input logic [5:0]  c);
      erbe_pkg::erbe_half_t r;
      logic [5:0]           cc;
      logic [4:0]           syn;
      cc   = enc16(d);
      syn  = c[4:0] ^ cc[4:0];
      r.d  = d;
      r.e  = 1'b0;
      r.ue = 1'b0;
      if (^{d, c}) begin
         r.e = 1'b1;
         for (int i = 0; i < 16; i++) begin
            if (HPOS[i] == syn) begin
               r.d[i] = ~d[i];
            end
         end
      end else if (syn != 5'h00) begin
         r.e  = 1'b1;
         r.ue = 1'b1;
      end
      return r;
   endfunction

   // even and odd bits go to separate codes, so any two adjacent flips
   // land one in each half and three adjacent flips leave a double in one
   function automatic logic [`ERBE_MW-1:0] enc32(input logic [`ERBE_EDW-1:0] d);
      logic [15:0] h0;
      logic [15:0] h1;
      for (int i = 0; i < 16; i++) begin
         h0[i] = d[2*i];
         h1[i] = d[2*i+1];
      end
      return {enc16(h1), enc16(h0), d};
   endfunction

   // a hopeless word goes out raw so software can inspect it
   function automatic erbe_pkg::erbe_dec_t dec32(input logic [`ERBE_MW-1:0] w);
      logic [15:0]          h0;
      logic [15:0]          h1;
      erbe_pkg::erbe_half_t r0;
      erbe_pkg::erbe_half_t r1;
      erbe_pkg::erbe_dec_t  r;
      for (int i = 0; i < 16; i++) begin
         h0[i] = w[2*i];
         h1[i] = w[2*i+1];
      end
      r0 = dec16(h0, w[37:32]);
      r1 = dec16(h1, w[43:38]);
      r.e  = r0.e | r1.e;
      r.ue = r0.ue | r1.ue;
      r.d  = w[`ERBE_EDW-1:0];
      if (!r.ue) begin
         for (int i = 0; i < 16; i++) begin
            r.d[2*i]   = r0.d[i];
            r.d[2*i+1] = r1.d[i];
         end
      end
      return r;
   endfunction

   // ports folded into arrays so one loop serves both
   assign p_wr    = {b_wren, a_wren};
   assign p_rd    = {b_rden, a_rden};
   assign p_ce    = {b_clken, a_clken};
   assign p_stall = {b_addr_stall, a_addr_stall};
   assign p_addr[0] = a_addr;
   assign p_addr[1] = b_addr;
   assign p_be[0]   = a_byteen;
   assign p_be[1]   = b_byteen;
   assign p_wd[0]   = a_wdata;
   assign p_wd[1]   = b_wdata;
   assign ecc_on    = (st_q.mode == erbe_pkg::ERBE_W32ECC);

   erbe_mem_if mif [2] ();

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         logic [`ERBE_MW-1:0] lmask;
         logic                pk;
         always_comb begin
            lmask = '0;
            for (int l = 0; l < `ERBE_LANES; l++) begin
               lmask[l*`ERBE_LW +: `ERBE_LW] = {`ERBE_LW{st_q.pt[g].be[l]}};
            end
            if (st_q.mode == erbe_pkg::ERBE_W20) begin
               lmask[`ERBE_DW-1:20] = '0;
            end
            // ecc words are always written whole
            if (ecc_on) begin
               lmask = '1;
            end
         end
         // ecc needs one address space, so packing is ignored there
         assign pk = st_q.packd & ~ecc_on;
         assign mif[g].addr  = pk ? {1'(g), st_q.pt[g].addr[`ERBE_AW-2:0]}
                                  : st_q.pt[g].addr;
         assign mif[g].we    = st_q.pt[g].wr;
         assign mif[g].wmask = lmask;
         assign mif[g].wdata = ecc_on ? enc32(st_q.pt[g].wd[`ERBE_EDW-1:0])
                                      : {4'h0, st_q.pt[g].wd};
         assign m_rd[g]      = mif[g].rdata;
      end
   endgenerate

   // the array registers its read data one edge after capture
   erbe_mem u_mem (
      .pclk (pclk),
      .pa   (mif[0]),
      .pb   (mif[1])
   );

   // the clear is caught without the clock and held until the next edge,
   // so a pulse shorter than a period still empties the outputs
   always_ff @(posedge pclk or posedge out_clr or negedge presetn) begin
      if (!presetn) begin
         clr_seen_q <= 1'b0;
      end else if (out_clr) begin
         clr_seen_q <= 1'b1;
      end else begin
         clr_seen_q <= 1'b0;
      end
   end

   assign clr_act = out_clr | clr_seen_q;

   // gated after the flop so a clear acts before any edge
   assign a_rdata = st_q.pt[0].rq & ~{`ERBE_DW{clr_act}};
   assign b_rdata = st_q.pt[1].rq & ~{`ERBE_DW{clr_act}};

   assign apb_wr   = psel & penable & pwrite;
   assign hit_cfg  = (paddr == `ERBE_REG_CFG);
   assign hit_stat = (paddr == `ERBE_REG_STAT);
   assign hit_cnt  = (paddr == `ERBE_REG_CNT);
   // zero wait states: every access ends in its first access cycle
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~(hit_cfg | hit_stat | hit_cnt);

   // reads have no side effects, so prdata may follow paddr
   always_comb begin
      prdata = 32'h00000000;
      if (hit_cfg) begin
         prdata[`ERBE_CFG_MODE_HI:`ERBE_CFG_MODE_LO] = st_q.mode;
         prdata[`ERBE_CFG_DC_BIT]   = st_q.dc;
         prdata[`ERBE_CFG_PIPE_BIT] = st_q.pipe;
         prdata[`ERBE_CFG_PACK_BIT] = st_q.packd;
      end else if (hit_stat) begin
         prdata[1:0] = st_q.stat;
      end else if (hit_cnt) begin
         prdata[15:0] = st_q.cnt;
      end
   end

   always_comb begin
      st_d   = st_q;
      dv     = 1'b0;
      raw    = '0;
      dec    = '0;
      merged = '0;
      if (apb_wr && hit_cfg) begin
         // a mode code that is not one-hot is ignored; changing mode while
         // ports are busy corrupts the words in flight
         case (pwdata[`ERBE_CFG_MODE_HI:`ERBE_CFG_MODE_LO])
            3'h1: st_d.mode = erbe_pkg::ERBE_W20;
            3'h2: st_d.mode = erbe_pkg::ERBE_W40;
            3'h4: st_d.mode = erbe_pkg::ERBE_W32ECC;
            default: st_d.mode = st_q.mode;
         endcase
         st_d.dc    = pwdata[`ERBE_CFG_DC_BIT];
         st_d.pipe  = pwdata[`ERBE_CFG_PIPE_BIT];
         st_d.packd = pwdata[`ERBE_CFG_PACK_BIT];
      end
      for (int p = 0; p < 2; p++) begin
         // input stage; ecc mode is simple dual-port: a writes, b reads
         st_d.pt[p].wr = 1'b0;
         st_d.pt[p].rd = 1'b0;
         if (p_ce[p]) begin
            if (!p_stall[p]) begin
               st_d.pt[p].addr = p_addr[p];
            end
            // a stalled port still takes data, lanes and strobes
            st_d.pt[p].wr = p_wr[p] & ~(ecc_on & (p == 1));
            st_d.pt[p].rd = p_rd[p] & ~(ecc_on & (p == 0));
            // the lane mask is forced on in ecc mode; users must not rely on it
            st_d.pt[p].be = ecc_on ? {`ERBE_LANES{1'b1}} : p_be[p];
            st_d.pt[p].wd = p_wd[p];
         end
         st_d.pt[p].s2wr = st_q.pt[p].wr;
         st_d.pt[p].s2rd = st_q.pt[p].rd;
         st_d.pt[p].s2be = st_q.pt[p].be;
         st_d.pt[p].s2wd = st_q.pt[p].wd;
         st_d.pt[p].pv   = st_q.pt[p].s2rd & st_q.pipe;
         st_d.pt[p].praw = m_rd[p];
         if (ecc_on && (p == 1)) begin
            dv  = st_q.pipe ? st_q.pt[p].pv : (st_q.pt[p].s2rd & ~st_q.pipe);
            raw = st_q.pipe ? st_q.pt[p].praw : m_rd[p];
            dec = dec32(raw);
            if (dv) begin
               st_d.pt[p].rq = '0;
               st_d.pt[p].rq[`ERBE_EDW-1:0] = dec.d;
               st_d.pt[p].rq[`ERBE_ST_ERR]  = dec.e;
               st_d.pt[p].rq[`ERBE_ST_UE]   = dec.ue;
               // stat keeps the last verdict; cnt wraps silently
               st_d.stat = {dec.e, dec.ue};
               if (dec.e && !dec.ue) begin
                  st_d.cnt = st_q.cnt + 16'h0001;
               end
            end
         end else if (!ecc_on && st_q.pt[p].s2wr) begin
            // m_rd still holds the word from before the write landed
            for (int l = 0; l < `ERBE_LANES; l++) begin
               if (st_q.pt[p].s2be[l]) begin
                  merged[l*`ERBE_LW +: `ERBE_LW] = st_q.pt[p].s2wd[l*`ERBE_LW +: `ERBE_LW];
               end else if (st_q.dc) begin
                  merged[l*`ERBE_LW +: `ERBE_LW] = `ERBE_DC_LANE;
               end else begin
                  merged[l*`ERBE_LW +: `ERBE_LW] = m_rd[p][l*`ERBE_LW +: `ERBE_LW];
               end
            end
            if (st_q.mode == erbe_pkg::ERBE_W20) begin
               merged[`ERBE_DW-1:20] = '0;
            end
            st_d.pt[p].rq = merged;
         end else if (!ecc_on && st_q.pt[p].s2rd) begin
            st_d.pt[p].rq = m_rd[p][`ERBE_DW-1:0];
            if (st_q.mode == erbe_pkg::ERBE_W20) begin
               st_d.pt[p].rq[`ERBE_DW-1:20] = '0;
            end
         end
         if (clr_seen_q) begin
            st_d.pt[p].rq = '0;
         end
      end
   end

   // array contents are never reset, only pipeline, settings, status and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

/* erbe_top_tb.sv */
`timescale 1ns/1ps
`include "erbe_consts.svh"

module erbe_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, out_clr, ecc, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0]  a_addr, b_addr;
   logic        a_wren, a_rden, a_clken, a_st, b_wren, b_rden, b_clken, b_st;
   logic [3:0]  a_be, b_be;
   logic [39:0] a_wdata, b_wdata, a_rdata, b_rdata;
   int          error_cnt;
   int          cmp_count;

   erbe_top erbe_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .a_addr(a_addr), .a_wren(a_wren), .a_rden(a_rden), .a_byteen(a_be),
      .a_wdata(a_wdata), .a_clken(a_clken), .a_addr_stall(a_st), .a_rdata(a_rdata),
      .b_addr(b_addr), .b_wren(b_wren), .b_rden(b_rden), .b_byteen(b_be), .b_wdata(b_wdata),
      .b_clken(b_clken), .b_addr_stall(b_st), .b_rdata(b_rdata), .out_clr(out_clr));
   erbe_fab_model ua (.clk(pclk), .ecc_on(ecc), .addr(a_addr), .wren(a_wren), .rden(a_rden),
      .byteen(a_be), .wdata(a_wdata), .clken(a_clken), .stall(a_st));
   erbe_fab_model ub (.clk(pclk), .ecc_on(ecc), .addr(b_addr), .wren(b_wren), .rden(b_rden),
      .byteen(b_be), .wdata(b_wdata), .clken(b_clken), .stall(b_st));

   always #5 pclk = ~pclk;

   task automatic finish_test();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk40(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t rdata %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t apb %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         $display("BAD %0t apb wait timed out", $time);
         finish_test();
      end
   endtask

   task automatic cfg(input logic [31:0] v);
      apb(1'b1, `ERBE_REG_CFG, v, rd, e);
      ecc = v[2];
   endtask

   task automatic op(input bit pb, input logic w, input logic r, input logic [3:0] be,
                     input logic [8:0] a, input logic [39:0] d, input logic s);
      if (pb) ub.req(w, r, be, a, d, s);
      else ua.req(w, r, be, a, d, s);
   endtask

   // result lands on the third edge after the request cycle
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   function automatic logic [39:0] mrg(input logic [39:0] o, input logic [39:0] n,
                                       input logic [3:0] be, input logic dc);
      for (int i = 0; i < 4; i++)
         mrg[i*10 +: 10] = be[i] ? n[i*10 +: 10] : (dc ? `ERBE_DC_LANE : o[i*10 +: 10]);
   endfunction

   task automatic t_apb();
      apb(1'b0, `ERBE_REG_CFG, 32'h0, rd, e);
      chk32(rd, 32'h00000002);
      apb(1'b0, `ERBE_REG_CNT, 32'h0, rd, e);
      chk32(rd, 32'h00000000);
      apb(1'b1, 12'hFFC, 32'hFFFFFFFF, rd, e);
      chk32({31'h0, e}, 32'h00000001);
      cfg(32'h0000003A);
      apb(1'b0, `ERBE_REG_CFG, 32'h0, rd, e);
      chk32(rd, 32'h0000003A);
      apb(1'b1, `ERBE_REG_CFG, 32'h00000007, rd, e);
      apb(1'b0, `ERBE_REG_CFG, 32'h0, rd, e);
      chk32(rd, 32'h00000002);
   endtask

   task automatic t_lanes(input logic [3:0] top, input logic [3:0] junk,
                          input logic [39:0] wm, input logic [31:0] c, input logic [8:0] a);
      logic [39:0] st;
      logic [39:0] nw;
      logic [3:0]  be;
      cfg(c);
      st = 40'hC3_5A96_A5C3 & wm;
      op(0, 1, 0, 4'hF, a, st, 0);
      settle();
      chk40(a_rdata, st);
      for (int i = 0; i < 5; i++) begin
         be = top >> i;
         nw = ~st ^ {4{10'(i)}};
         cfg(c | {28'h0, i[0], 3'h0});
         op(0, 1, 0, be | junk, a, nw, 0);
         settle();
         chk40(a_rdata, mrg(st, nw, be, i[0]) & wm);
         st = mrg(st, nw, be, 1'b0) & wm;
         op(0, 0, 1, 4'hF, a, 40'h0, 0);
         settle();
         chk40(a_rdata, st);
      end
   endtask

   task automatic t_stall();
      cfg(32'h00000002);
      op(0, 1, 0, 4'hF, 9'h010, 40'h11_1111_1111, 0);
      op(0, 1, 0, 4'hF, 9'h011, 40'h22_2222_2222, 0);
      op(0, 0, 1, 4'hF, 9'h011, 40'h0, 0);
      fork
         op(0, 0, 1, 4'hF, 9'h010, 40'h0, 1);
         op(1, 0, 1, 4'hF, 9'h010, 40'h0, 0);
      join
      settle();
      chk40(a_rdata, 40'h22_2222_2222);
      chk40(b_rdata, 40'h11_1111_1111);
      op(0, 1, 0, 4'hF, 9'h010, 40'h33_3333_3333, 1);
      op(0, 0, 1, 4'hF, 9'h010, 40'h0, 0);
      settle();
      chk40(a_rdata, 40'h11_1111_1111);
      op(0, 0, 1, 4'hF, 9'h011, 40'h0, 0);
      settle();
      chk40(a_rdata, 40'h33_3333_3333);
   endtask

   task automatic t_clr();
      @(posedge pclk);
      out_clr <= 1'b1;
      #1;
      chk40(a_rdata | b_rdata, 40'h0);
      @(posedge pclk);
      out_clr <= 1'b0;
      #1;
      chk40(a_rdata | b_rdata, 40'h0);
      repeat (3) @(posedge pclk);
      #1;
      chk40(a_rdata | b_rdata, 40'h0);
      op(0, 0, 1, 4'hF, 9'h011, 40'h0, 0);
      settle();
      chk40(a_rdata, 40'h33_3333_3333);
   endtask

   task automatic t_pack();
      cfg(32'h00000022);
      fork
         op(0, 1, 0, 4'hF, 9'h005, 40'hAA_0000_5555, 0);
         op(1, 1, 0, 4'hF, 9'h005, 40'h55_FFFF_AAAA, 0);
      join
      fork
         op(0, 0, 1, 4'hF, 9'h105, 40'h0, 0);
         op(1, 0, 1, 4'hF, 9'h005, 40'h0, 0);
      join
      settle();
      chk40(a_rdata, 40'hAA_0000_5555);
      chk40(b_rdata, 40'h55_FFFF_AAAA);
      cfg(32'h00000002);
      op(0, 0, 1, 4'hF, 9'h105, 40'h0, 0);
      settle();
      chk40(a_rdata, 40'h55_FFFF_AAAA);
   endtask

   task automatic t_ecc();
      cfg(32'h00000004);
      op(0, 1, 0, 4'hF, 9'h007, 40'hC3_DEAD_0001, 0);
      op(0, 1, 0, 4'hF, 9'h008, 40'h00_0F0F_8000, 0);
      op(1, 0, 1, 4'hF, 9'h007, 40'h0, 0);
      settle();
      chk40(b_rdata, 40'h00_DEAD_0001);
      cfg(32'h00000014);
      op(1, 0, 1, 4'hF, 9'h008, 40'h0, 0);
      settle();
      chk40(b_rdata, 40'h00_DEAD_0001);
      @(posedge pclk);
      #1;
      chk40(b_rdata, 40'h00_0F0F_8000);
      apb(1'b0, `ERBE_REG_STAT, 32'h0, rd, e);
      chk32(rd, 32'h00000000);
   endtask

   // flips lane 0 of an ecc word through a plain 40-bit write
   task automatic t_fix(input logic [9:0] f, input logic [1:0] s, input logic [15:0] n);
      cfg(32'h00000004);
      op(0, 1, 0, 4'hF, 9'h009, 40'h00_1234_5678, 0);
      cfg(32'h00000002);
      op(0, 1, 0, 4'h1, 9'h009, {30'h0, 10'h278 ^ f}, 0);
      cfg(32'h00000004);
      op(1, 0, 1, 4'hF, 9'h009, 40'h0, 0);
      settle();
      chk40(b_rdata, {s, 6'h00, 32'h1234_5678 ^ {22'h0, s[0] ? f : 10'h000}});
      apb(1'b0, `ERBE_REG_STAT, 32'h0, rd, e);
      chk32(rd, {30'h0, s});
      apb(1'b0, `ERBE_REG_CNT, 32'h0, rd, e);
      chk32(rd, {16'h0, n});
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      out_clr = 1'b0;
      ecc = 1'b0;
      error_cnt = 0;
      cmp_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_apb();
      t_lanes(4'h8, 4'h0, 40'hFF_FFFF_FFFF, 32'h00000002, 9'h003);
      t_lanes(4'h2, 4'hC, 40'h00_000F_FFFF, 32'h00000001, 9'h013);
      t_stall();
      t_clr();
      t_pack();
      t_ecc();
      t_fix(10'h001, 2'b10, 16'h0001);
      t_fix(10'h003, 2'b10, 16'h0002);
      t_fix(10'h007, 2'b11, 16'h0002);
      finish_test();
   end
endmodule

bind erbe_top erbe_monitor erbe_monitor_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .a_rdata(a_rdata), .b_rdata(b_rdata), .out_clr(out_clr));
